// file: src/pifb_top.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
// Operation
// - four external pin flags set on detected pin events, held until software clears
// - peripheral enable does not gate pin, pin change or timer0 requests
// - pin change summary is read-only, clears when all per-pin flags clear
// - each external interrupt input picks its pin by its own select register
// - oscillator fail flag bit 7 sets on failure, held until software clears
// - clock switch flag bit 6 sets when new oscillator ready, software clears
// - clock switch flag never wakes the device from sleep
// - adc threshold bit 1 and conversion done bit 0 set, software clears
// - voltage detect flag sets on event, reads zero when detector unconfigured
// - zero cross flag sets on any output change, held until cleared
// - comparator flags bits 0 to 2 set on output change, held until cleared
// - receive flags channels 1,2 reflect full buffer, cleared by data read
// - transmit flags channels 1,2 read one while buffer empty
// - bus collision flags bits 1 and 3 set on collision, software clears
// - sync port flags bits 0 and 2 set on transfer completion
// - fourth register: upper nibble read-only, lower read/write, reset zero
// - fifth register mirrors channels 3 to 5 receive/transmit, read-only
// - sixth register holds eight read/write timer match flags, reset zero
// - flags set on their condition regardless of any enable
module pifb_top
  import pifb_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [15:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [N_GPIO-1:0] GPIO_I,
  input wire pifb_evt_t EVT_I,
  input wire pifb_ser_t SER_I,
  output logic CORE_REQ_O,
  output logic WAKE_REQ_O
);

  // =========================================================
  // bus decode
  // =========================================================
  logic ack_ff;
  logic [REG_W-1:0] rdata_ff;
  logic [REG_W-1:0] nxt_rdata;
  wire logic [11:0] idx = ADR_I[13:2];
  wire logic in_range = (ADR_I[15:14] == 2'h0);
  wire logic req = CYC_I & STB_I & ~ack_ff;
  // writes take only the low byte lane
  wire logic wr = req & WE_I & SEL_I[0];
  wire logic [REG_W-1:0] wdat = DAT_I[REG_W-1:0];
  wire logic wr_ext = wr & in_range & (idx == IDX_EXT_CORE_FLAGS);
  wire logic wr_cka = wr & in_range & (idx == IDX_CLOCK_ADC_EVENT_FLAGS);
  wire logic wr_ana = wr & in_range & (idx == IDX_ANALOG_EVENT_FLAGS);
  wire logic wr_slo = wr & in_range & (idx == IDX_SERIAL_LOW_CHANNEL_FLAGS);
  wire logic wr_tmr = wr & in_range & (idx == IDX_TIMER_MATCH_FLAGS);
  wire logic wr_ctl = wr & in_range & (idx == IDX_IRQ_CONTROL);
  wire logic wr_ppc = wr & in_range & (idx == IDX_PER_PIN_CHANGE_FLAGS);

  // =========================================================
  // pin synchronisers and filters
  // =========================================================
  logic [N_GPIO-1:0] s1_ff;
  logic [N_GPIO-1:0] s2_ff;
  logic [N_GPIO-1:0] s3_ff;
  logic [N_GPIO-1:0] pin_ff;
  logic [N_GPIO-1:0] pin_rise;
  logic [N_GPIO-1:0] pin_fall;
  logic [N_GPIO-1:0] ppc_ff;
  logic [N_GPIO-1:0] nxt_ppc;

  genvar g;
  generate
    for (g = 0; g < N_GPIO; g++)
    begin : g_pin
      // a level counts only once two late stages agree, masking a metastable stage
      always_ff @(posedge CLK_SYS_I or negedge NRST_I)
      begin
        if (!NRST_I)
        begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
          s3_ff[g] <= 1'b0;
          pin_ff[g] <= 1'b0;
        end
        else
        begin
          s1_ff[g] <= GPIO_I[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g])
            pin_ff[g] <= s3_ff[g];
        end
      end
      assign pin_rise[g] = (s2_ff[g] == s3_ff[g]) & s3_ff[g] & ~pin_ff[g];
      assign pin_fall[g] = (s2_ff[g] == s3_ff[g]) & ~s3_ff[g] & pin_ff[g];
      // software writes zero to clear; a change in the same cycle survives
      assign nxt_ppc[g] = (pin_rise[g] | pin_fall[g])
        | (wr_ppc ? wdat[g] : ppc_ff[g]);
    end
  endgenerate

  // =========================================================
  // external pin events
  // =========================================================
  logic [SEL_W-1:0] ext_sel_ff [N_EXT];
  logic [REG_W-1:0] ctl_ff;
  logic [N_EXT-1:0] ext_set;

  generate
    for (g = 0; g < N_EXT; g++)
    begin : g_ext
      wire logic wr_sel = wr & in_range & (idx == IDX_EXT_PIN_SELECT0 + 12'(g));
      always_ff @(posedge CLK_SYS_I or negedge NRST_I)
      begin
        if (!NRST_I)
          ext_sel_ff[g] <= SELECT_RESET;
        else if (wr_sel)
          ext_sel_ff[g] <= wdat[SEL_W-1:0];
      end
      // edge select: one picks rising, zero falling
      assign ext_set[g] = ctl_ff[g] ? pin_rise[ext_sel_ff[g]]
        : pin_fall[ext_sel_ff[g]];
    end
  endgenerate

  // =========================================================
  // peripheral change detection
  // =========================================================
  logic zc_prev_ff;
  logic [N_CMP-1:0] cmp_prev_ff;
  wire logic zc_change = EVT_I.zero_cross_out ^ zc_prev_ff;
  wire logic [N_CMP-1:0] cmp_change = EVT_I.cmp_out ^ cmp_prev_ff;

  // =========================================================
  // flag next values: set | (write ? data : hold) on writable bits
  // =========================================================
  logic [REG_W-1:0] ext_ff;
  logic [REG_W-1:0] cka_ff;
  logic [REG_W-1:0] ana_ff;
  logic [REG_W-1:0] slo_ff;
  logic [REG_W-1:0] shi_ff;
  logic [REG_W-1:0] tmr_ff;
  logic [REG_W-1:0] ext_set_v;
  logic [REG_W-1:0] cka_set_v;
  logic [REG_W-1:0] ana_set_v;
  logic [REG_W-1:0] slo_set_v;
  logic [REG_W-1:0] nxt_ext;
  logic [REG_W-1:0] nxt_cka;
  logic [REG_W-1:0] nxt_ana;
  logic [REG_W-1:0] nxt_slo;
  logic [REG_W-1:0] nxt_shi;
  logic [REG_W-1:0] nxt_tmr;
  logic [REG_W-1:0] nxt_ctl;

  // sets ignore every enable so software can poll
  assign ext_set_v = {2'h0, EVT_I.tmr0_ovf, 1'b0, ext_set};
  assign cka_set_v = {EVT_I.osc_fail, EVT_I.clk_switch_ready,
    4'h0, EVT_I.adc_thresh, EVT_I.adc_done};
  assign ana_set_v = {EVT_I.volt_detect, zc_change, 3'h0, cmp_change};
  assign slo_set_v = {4'h0, EVT_I.bus_collision[1], EVT_I.sync_port_done[1],
    EVT_I.bus_collision[0], EVT_I.sync_port_done[0]};

  // summary bit is a pure function of the per-pin flags; writes land nowhere
  assign nxt_ext = (ext_set_v | (wr_ext ? (wdat & EXT_RW_MASK) : (ext_ff & EXT_RW_MASK)))
    & EXT_RW_MASK | ({7'h0, |nxt_ppc} << BIT_PIN_CHANGE_SUM);
  assign nxt_cka = (cka_set_v | (wr_cka ? wdat : cka_ff)) & CLOCK_ADC_RW_MASK;
  // an unconfigured detector forces its flag to zero
  assign nxt_ana = ((ana_set_v | (wr_ana ? wdat : ana_ff)) & ANALOG_RW_MASK)
    & ~({7'h0, ~EVT_I.volt_detect_cfg} << BIT_VOLT_DETECT);
  // upper nibble follows the buffers: full rx / empty tx, channels 2,1
  assign nxt_slo = {SER_I.rx_full[1], SER_I.tx_empty[1],
    SER_I.rx_full[0], SER_I.tx_empty[0],
    (slo_set_v[3:0] | (wr_slo ? wdat[3:0] : slo_ff[3:0]))};
  assign nxt_shi = {2'h0, SER_I.rx_full[4], SER_I.tx_empty[4],
    SER_I.rx_full[3], SER_I.tx_empty[3], SER_I.rx_full[2], SER_I.tx_empty[2]};
  assign nxt_tmr = EVT_I.tmr_match | (wr_tmr ? wdat : tmr_ff);
  assign nxt_ctl = wr_ctl ? wdat : ctl_ff;

  // =========================================================
  // read mux
  // =========================================================
  always_comb
  begin
    nxt_rdata = FLAGS_RESET;
    if (in_range)
    begin
      case (idx)
        IDX_EXT_CORE_FLAGS: nxt_rdata = ext_ff;
        IDX_CLOCK_ADC_EVENT_FLAGS: nxt_rdata = cka_ff;
        IDX_ANALOG_EVENT_FLAGS: nxt_rdata = ana_ff;
        IDX_SERIAL_LOW_CHANNEL_FLAGS: nxt_rdata = slo_ff;
        IDX_SERIAL_HIGH_CHANNEL_FLAGS: nxt_rdata = shi_ff;
        IDX_TIMER_MATCH_FLAGS: nxt_rdata = tmr_ff;
        IDX_IRQ_CONTROL: nxt_rdata = ctl_ff;
        IDX_PER_PIN_CHANGE_FLAGS: nxt_rdata = ppc_ff;
        default:
        begin
          if (idx[11:2] == IDX_EXT_PIN_SELECT0[11:2])
            nxt_rdata = {5'h0, ext_sel_ff[idx[1:0]]};
        end
      endcase
    end
  end

  // =========================================================
  // flag registers, one short process each
  // =========================================================
  // first register: pin flags, summary, timer0
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      ext_ff <= FLAGS_RESET;
    else
      ext_ff <= nxt_ext;
  end

  // clock and converter events
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      cka_ff <= FLAGS_RESET;
    else
      cka_ff <= nxt_cka;
  end

  // analog events
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      ana_ff <= FLAGS_RESET;
    else
      ana_ff <= nxt_ana;
  end

  // serial channels 1 and 2, sync ports
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      slo_ff <= FLAGS_RESET;
    else
      slo_ff <= nxt_slo;
  end

  // serial channels 3 to 5, pure mirror
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      shi_ff <= FLAGS_RESET;
    else
      shi_ff <= nxt_shi;
  end

  // timer match flags
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      tmr_ff <= FLAGS_RESET;
    else
      tmr_ff <= nxt_tmr;
  end

  // per-pin change flags
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      ppc_ff <= FLAGS_RESET;
    else
      ppc_ff <= nxt_ppc;
  end

  // =========================================================
  // control and change history
  // =========================================================
  // edge selects reset to rising, peripheral enable off
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      ctl_ff <= CONTROL_RESET;
    else
      ctl_ff <= nxt_ctl;
  end

  // history starts low: a source already high after reset counts as a change
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      zc_prev_ff <= 1'b0;
      cmp_prev_ff <= '0;
    end
    else
    begin
      zc_prev_ff <= EVT_I.zero_cross_out;
      cmp_prev_ff <= EVT_I.cmp_out;
    end
  end

  // =========================================================
  // bus answer
  // =========================================================
  // ack one cycle after the request; the mask on req keeps it a pulse
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      ack_ff <= 1'b0;
    else
      ack_ff <= req;
  end

  // read data registered every cycle from the live register, so it follows flag changes while the request stands
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      rdata_ff <= FLAGS_RESET;
    else
      rdata_ff <= nxt_rdata;
  end

  assign ACK_O = ack_ff;
  assign DAT_O = {24'h0, rdata_ff};

  // =========================================================
  // requests towards the core
  // =========================================================
  wire logic direct_req = |(ext_ff & EXT_RW_MASK) | ext_ff[BIT_PIN_CHANGE_SUM];
  wire logic [REG_W-1:0] cka_wake = cka_ff & ~(8'h01 << BIT_CLK_SWITCH);
  wire logic periph_any = |{cka_ff, ana_ff, slo_ff, shi_ff, tmr_ff};
  wire logic periph_wake = |{cka_wake, ana_ff, slo_ff, shi_ff, tmr_ff};

  // pin, pin change and timer0 requests bypass the peripheral enable
  assign CORE_REQ_O = direct_req | (ctl_ff[BIT_PERIPH_ENABLE] & periph_any);
  // a pending clock switch alone must leave the core asleep
  assign WAKE_REQ_O = direct_req | periph_wake;

endmodule // pifb_top

// file: src/pifb_pkg.sv
package pifb_pkg;

  // =========================================================
  // register indices (byte address = index * 4)
  // =========================================================
  localparam logic [11:0] IDX_EXT_CORE_FLAGS = 12'hE33;
  localparam logic [11:0] IDX_CLOCK_ADC_EVENT_FLAGS = 12'hE34;
  localparam logic [11:0] IDX_ANALOG_EVENT_FLAGS = 12'hE35;
  localparam logic [11:0] IDX_SERIAL_LOW_CHANNEL_FLAGS = 12'hE36;
  localparam logic [11:0] IDX_SERIAL_HIGH_CHANNEL_FLAGS = 12'hE37;
  localparam logic [11:0] IDX_TIMER_MATCH_FLAGS = 12'hE38;
  localparam logic [11:0] IDX_EXT_PIN_SELECT0 = 12'hE40;
  localparam logic [11:0] IDX_IRQ_CONTROL = 12'hE44;
  localparam logic [11:0] IDX_PER_PIN_CHANGE_FLAGS = 12'hE45;

  // =========================================================
  // widths and field layout
  // =========================================================
  localparam int REG_W = 8;
  localparam int N_GPIO = 8;
  localparam int N_EXT = 4;
  localparam int SEL_W = 3;
  localparam int N_CMP = 3;
  localparam int N_SER = 5;
  localparam int N_TMR = 8;

  // first flag register
  localparam logic [7:0] EXT_RW_MASK = 8'h2F;
  localparam int BIT_PIN_CHANGE_SUM = 4;
  localparam int BIT_TMR0_OVF = 5;
  // second flag register
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_CLK_SWITCH = 6;
  localparam int BIT_ADC_THRESH = 1;
  localparam int BIT_ADC_DONE = 0;
  localparam logic [7:0] CLOCK_ADC_RW_MASK = 8'hC3;
  // third flag register
  localparam int BIT_VOLT_DETECT = 7;
  localparam int BIT_ZERO_CROSS = 6;
  localparam logic [7:0] ANALOG_RW_MASK = 8'hC7;
  // fourth flag register: upper nibble mirrors serial buffers
  localparam logic [7:0] SERIAL_LOW_RW_MASK = 8'h0F;
  // control register
  localparam int BIT_PERIPH_ENABLE = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h0F;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [2:0] SELECT_RESET = 3'h0;

  // =========================================================
  // event carriers, peripherals on the system clock
  // =========================================================
  typedef struct packed {
    logic osc_fail;
    logic clk_switch_ready;
    logic adc_thresh;
    logic adc_done;
    logic volt_detect;
    logic volt_detect_cfg;
    logic zero_cross_out;
    logic [N_CMP-1:0] cmp_out;
    logic [1:0] bus_collision;
    logic [1:0] sync_port_done;
    logic tmr0_ovf;
    logic [N_TMR-1:0] tmr_match;
  } pifb_evt_t;

  typedef struct packed {
    logic [N_SER-1:0] rx_full;
    logic [N_SER-1:0] tx_empty;
  } pifb_ser_t;

endpackage

// file: dv/pifb_periph_model.sv
`timescale 1ns/1ps
module pifb_periph_model
  import pifb_pkg::*;
(
  input wire logic clk_i,
  output pifb_evt_t evt_o,
  output pifb_ser_t ser_o
);
  // ==========================================
  // event sources and serial buffer levels
  initial
  begin
    evt_o = '0;
    ser_o = '0;
  end
  // one-cycle event then a quiet gap; a slow source answers late
  task automatic pulse(input pifb_evt_t e, input int gap);
    pifb_evt_t z;
    z = '0;
    z.volt_detect_cfg = e.volt_detect_cfg; // detector setup outlives the event
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= z; // levels fall back, a second change
    repeat (gap) @(posedge clk_i);
  endtask
  // full drops on a data read, empty on a data write, both peripheral side
  task automatic ser_set(input pifb_ser_t s);
    ser_o <= s;
  endtask
endmodule // pifb_periph_model

// file: dv/pifb_monitor.sv
`timescale 1ns/1ps
module pifb_monitor
  import pifb_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire pifb_evt_t EVT_I,
  input wire pifb_ser_t SER_I,
  input wire logic CORE_REQ_O,
  input wire logic WAKE_REQ_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  // ==========================================
  // register bus
  property p_ack_next; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_hi_zero; DAT_O[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("read data upper bits");
  property p_rst_quiet; $rose(NRST_I) |-> !ACK_O && DAT_O == 32'h0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus busy at reset");
  // ==========================================
  // events reach the requests, no enable involved
  property p_tmr0_bypass; EVT_I.tmr0_ovf |=> CORE_REQ_O && WAKE_REQ_O; endproperty
  a_tmr0_bypass: assert property (p_tmr0_bypass) else $error("timer0 gated");
  property p_osc_wake; EVT_I.osc_fail || EVT_I.adc_done |=> WAKE_REQ_O; endproperty
  a_osc_wake: assert property (p_osc_wake) else $error("event lost");
  property p_ser_mirror; |SER_I.rx_full |=> WAKE_REQ_O; endproperty
  a_ser_mirror: assert property (p_ser_mirror) else $error("rx full lost");
  // past reset only, the change detector needs one clean sample
  property p_zc; $past(NRST_I) && $changed(EVT_I.zero_cross_out) |=> WAKE_REQ_O; endproperty
  a_zc: assert property (p_zc) else $error("zero cross lost");
  c_ack: cover property (ACK_O);
  c_wake_only: cover property (WAKE_REQ_O && !CORE_REQ_O);
  c_csw: cover property (EVT_I.clk_switch_ready ##1 !WAKE_REQ_O);
endmodule // pifb_monitor
bind pifb_top pifb_monitor u_mon (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .EVT_I(EVT_I), .SER_I(SER_I),
  .CORE_REQ_O(CORE_REQ_O), .WAKE_REQ_O(WAKE_REQ_O));

// file: dv/pifb_tb.sv
`timescale 1ns/1ps
module tb;
  import pifb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [7:0] gpio = 8'h0;
  logic [31:0] rdat;
  logic ack, core, wake;
  pifb_evt_t evt;
  pifb_ser_t ser;
  int err_count = 0;
  int compares = 0;
  pifb_top uut (.CLK_SYS_I(clk), .NRST_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .DAT_I(dat), .SEL_I(sel), .DAT_O(rdat), .ACK_O(ack), .GPIO_I(gpio),
    .EVT_I(evt), .SER_I(ser), .CORE_REQ_O(core), .WAKE_REQ_O(wake));
  pifb_periph_model pm (.clk_i(clk), .evt_o(evt), .ser_o(ser));
  initial
  begin
    forever #10 clk = ~clk;
  end
  // ==========================================
  // bus cycles and expectations
  function automatic logic [11:0] ri(input int i);
    return IDX_EXT_CORE_FLAGS + 12'(i);
  endfunction
  function automatic logic [7:0] xr(input int i, input pifb_evt_t e, input pifb_ser_t s);
    case (i)
      0: return {2'h0, e.tmr0_ovf, 5'h00};
      1: return {e.osc_fail, e.clk_switch_ready, 4'h0, e.adc_thresh, e.adc_done};
      2: return {e.volt_detect & e.volt_detect_cfg, e.zero_cross_out, 3'h0, e.cmp_out};
      3: return {s.rx_full[1], s.tx_empty[1], s.rx_full[0], s.tx_empty[0],
        e.bus_collision[1], e.sync_port_done[1], e.bus_collision[0], e.sync_port_done[0]};
      4: return {2'h0, s.rx_full[4], s.tx_empty[4], s.rx_full[3], s.tx_empty[3],
        s.rx_full[2], s.tx_empty[2]};
      default: return e.tmr_match;
    endcase
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, x, s);
    end
  endtask
  // no cycle count assumed: waits for ack, bounded
  task automatic wb(input logic w, input logic [11:0] i, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'h0, i, 2'h0};
    dat <= {24'h0, wd};
    sel <= 4'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) err_count++;
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] i, input logic [7:0] wd);
    logic [7:0] d;
    wb(1'b1, i, wd, d);
  endtask
  task automatic rc(input logic [11:0] i, input logic [7:0] x);
    logic [7:0] d;
    wb(1'b0, i, 8'h00, d);
    chk($sformatf("reg %h", i), d, x);
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  // ==========================================
  // scenarios
  initial
  begin
    pifb_evt_t e;
    pifb_ser_t s;
    logic en;
    logic [7:0] x, c, a;
    void'($urandom(32'hA3B3));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rc(ri(i), 8'h00);
    rc(12'h100, 8'h00);
    for (int r = 0; r < 30; r++)
    begin
      e = pifb_evt_t'($bits(pifb_evt_t)'($urandom));
      if (r == 0) e = pifb_evt_t'(23'h200000); // clock switch alone
      if (r == 1) e = pifb_evt_t'(23'h040000); // detector not set up
      en = 1'($urandom);
      wr(IDX_IRQ_CONTROL, {en, 7'h0F});
      pm.pulse(e, r % 3);
      @(negedge clk);
      x = xr(0, e, '0);
      c = xr(1, e, '0);
      a = xr(2, e, '0) | xr(3, e, '0) | xr(5, e, '0);
      chk("core", 8'(core), 8'(|x || (en && |(a | c))));
      chk("wake", 8'(wake), 8'(|x || |(a | (c & 8'hBF))));
      for (int i = 0; i < 6; i++) rc(ri(i), xr(i, e, '0));
      for (int i = 0; i < 6; i++) wr(ri(i), 8'h00);
    end
    e = '0;
    e.tmr_match = 8'hFF;
    fork
      wr(IDX_TIMER_MATCH_FLAGS, 8'h00);
      begin
        @(posedge clk);
        pm.pulse(e, 0);
      end
    join
    rc(IDX_TIMER_MATCH_FLAGS, 8'hFF);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc(IDX_TIMER_MATCH_FLAGS, 8'h00);
    for (int r = 0; r < 6; r++)
    begin
      s = pifb_ser_t'(10'($urandom));
      pm.ser_set(s);
      wr(ri(3), 8'hFF);
      wr(ri(4), 8'hFF);
      rc(ri(3), xr(3, '0, s) | 8'h0F);
      rc(ri(4), xr(4, '0, s));
      wr(ri(3), 8'h00);
    end
    pm.ser_set('0);
    // each input picks its own pin; unused pins never move
    for (int k = 0; k < N_EXT; k++)
    begin
      wr(IDX_EXT_PIN_SELECT0 + 12'(k), 8'(7 - k));
      gpio[7 - k] <= 1'b1;
      repeat (4) @(posedge clk);
      rc(ri(0), 8'h10 | 8'((2 << k) - 1));
    end
    rc(IDX_PER_PIN_CHANGE_FLAGS, 8'hF0);
    wr(ri(0), 8'h00);
    rc(ri(0), 8'h10);
    wr(IDX_PER_PIN_CHANGE_FLAGS, 8'h00);
    wr(ri(0), 8'h10);
    rc(ri(0), 8'h00);
    // falling edge select on input 0, which watches pin 7
    wr(IDX_IRQ_CONTROL, 8'h0E);
    gpio[7] <= 1'b0;
    repeat (4) @(posedge clk);
    rc(ri(0), 8'h11);
    tally_and_finish();
  end
endmodule // tb
